//--- common/sample_fifo_pkg.sv
// Package: register map, field layout and carrier types of the sample buffer
package sample_fifo_pkg;
  localparam int          DEPTH        = 512;
  localparam int          AW           = 9;
  localparam int          LW           = 10;
  localparam logic [7:0]  ADDR_THRESH  = 8'hFC;
  localparam logic [7:0]  ADDR_HIGH    = 8'hFD;
  localparam logic [7:0]  ADDR_LOW     = 8'hFE;
  localparam logic [7:0]  ADDR_DATA    = 8'hFF;
  localparam int          OVF_BIT      = 7;
  localparam int          UNF_BIT      = 6;
  localparam logic [7:0]  THRESH_RST   = 8'h7F;
  localparam logic [7:0]  EMPTY_READ   = 8'h00;
  localparam logic [LW-1:0] LEVEL_RST  = 10'h000;

  // Register access from the serial bus front end
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0]    thresh;
    logic [LW-1:0] level;
    logic [AW-1:0] rptr;
    logic [AW-1:0] wptr;
    logic          ovf;
    logic          unf;
    logic [3:0]    snap;
    logic [7:0]    rdata;
    logic          irq;
  } fifo_state_t;
endpackage

//--- rtl/sample_fifo_readout.sv
// Read side of the 512-byte sample buffer with status and data port
// Notes on behaviour
// RULE1: 512-byte store, fill count 0 to 512
// RULE2: count 9:2 in high, 1:0 in low
// RULE3: host reads high register before low one
// RULE4: high read snapshots low bits and flags
// RULE5: push when full is dropped, overflow set
// RULE6: flags clear on power-on enable or flush
// RULE7: empty data read returns zero, underflow set
// RULE8: data read pops oldest byte, count decrements
// RULE9: single and block reads pop in order
// RULE10: host checks flags before and after draining
// RULE11: irq when count exceeds threshold bits 8:1
`timescale 1ns/1ps
`default_nettype none
module sample_fifo_readout (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire sample_fifo_pkg::reg_req_t req,
  input  wire logic                      power_on_enable,
  input  wire logic                      buffer_flush_cmd,
  input  wire logic                      push_valid,
  input  wire logic [7:0]                push_data,
  output logic [7:0]                     rdata,
  output logic                           buffer_irq
);
  // ----------------------------------------
  // Storage and state
  // ----------------------------------------
  sample_fifo_pkg::fifo_state_t s_r;
  sample_fifo_pkg::fifo_state_t s_nxt;
  logic [7:0] mem_r [sample_fifo_pkg::DEPTH];
  logic       clr;
  logic       pop;
  logic       pop_empty;
  logic       push_ok;

  assign clr       = power_on_enable | buffer_flush_cmd;
  assign pop       = req.rd && req.addr == sample_fifo_pkg::ADDR_DATA;
  assign pop_empty = pop && s_r.level == sample_fifo_pkg::LEVEL_RST;
  // Full store refuses the byte; a pop in the same cycle does not make room
  assign push_ok   = push_valid && !clr &&
                     s_r.level != 10'(sample_fifo_pkg::DEPTH); // RULE1 RULE5

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (push_ok) begin
      s_nxt.wptr = s_r.wptr + 9'h001;
    end
    if (pop && !pop_empty && !clr) begin
      s_nxt.rptr = s_r.rptr + 9'h001; // RULE8 RULE9
    end
    s_nxt.level = s_r.level + 10'(push_ok)
                  - 10'(pop && !pop_empty && !clr); // RULE1 RULE8
    if (push_valid && !push_ok && !clr) begin
      s_nxt.ovf = 1'b1; // RULE5
    end
    if (pop_empty && !clr) begin
      s_nxt.unf = 1'b1; // RULE7
    end
    if (req.wr && req.addr == sample_fifo_pkg::ADDR_THRESH) begin
      s_nxt.thresh = req.wdata;
    end
    s_nxt.rdata = sample_fifo_pkg::EMPTY_READ;
    if (req.rd) begin
      unique case (req.addr)
        sample_fifo_pkg::ADDR_THRESH: s_nxt.rdata = s_r.thresh;
        sample_fifo_pkg::ADDR_HIGH: begin
          s_nxt.rdata = s_r.level[9:2]; // RULE2
          s_nxt.snap  = {s_r.ovf, s_r.unf, s_r.level[1:0]}; // RULE4
        end
        sample_fifo_pkg::ADDR_LOW:
          s_nxt.rdata = {s_r.snap[3:2], 4'h0, s_r.snap[1:0]}; // RULE2 RULE4
        sample_fifo_pkg::ADDR_DATA:
          s_nxt.rdata = pop_empty ? sample_fifo_pkg::EMPTY_READ
                                  : mem_r[s_r.rptr]; // RULE7 RULE8
        default: s_nxt.rdata = sample_fifo_pkg::EMPTY_READ;
      endcase
    end
    if (clr) begin
      s_nxt.ovf   = 1'b0; // RULE6
      s_nxt.unf   = 1'b0; // RULE6
      s_nxt.level = sample_fifo_pkg::LEVEL_RST;
      s_nxt.rptr  = '0;
      s_nxt.wptr  = '0;
      s_nxt.snap  = 4'h0;
    end
    // Next threshold used so irq agrees with a fresh write at once
    s_nxt.irq = s_nxt.level > {1'b0, s_nxt.thresh, 1'b0}; // RULE11
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_r        <= '0;
      s_r.thresh <= sample_fifo_pkg::THRESH_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Write port kept outside the state struct to avoid a huge reset net
  always_ff @(posedge clk) begin
    if (push_ok) begin
      mem_r[s_r.wptr] <= push_data;
    end
  end

  assign rdata      = s_r.rdata;
  assign buffer_irq = s_r.irq;

  // ----------------------------------------
  // Fill count and overflow checks
  // ----------------------------------------
  a_level_bound: assert property ( // RULE1
    @(posedge clk) disable iff (!resetn)
    s_r.level <= 10'(sample_fifo_pkg::DEPTH))
    else $error("fill count above capacity");

  a_push_count: assert property ( // RULE1
    @(posedge clk) disable iff (!resetn)
    push_ok && !pop |=> s_r.level == $past(s_r.level) + 10'h001)
    else $error("push did not raise fill count");

  a_full_drop: assert property ( // RULE5
    @(posedge clk) disable iff (!resetn)
    push_valid && s_r.level == 10'(sample_fifo_pkg::DEPTH) && !clr
    |=> s_r.ovf)
    else $error("overflow not flagged");

  a_full_keep: assert property ( // RULE5
    @(posedge clk) disable iff (!resetn)
    push_valid && s_r.level == 10'(sample_fifo_pkg::DEPTH) && !pop && !clr
    |=> s_r.level == 10'(sample_fifo_pkg::DEPTH))
    else $error("dropped byte changed fill count");

  // ----------------------------------------
  // Flag and clear checks
  // ----------------------------------------
  a_flag_clear: assert property ( // RULE6
    @(posedge clk) disable iff (!resetn)
    clr |=> !s_r.ovf && !s_r.unf)
    else $error("flags not cleared");

  a_level_clear: assert property ( // RULE6
    @(posedge clk) disable iff (!resetn)
    clr |=> s_r.level == sample_fifo_pkg::LEVEL_RST)
    else $error("fill count not cleared");

  a_ovf_sticky: assert property ( // RULE6
    @(posedge clk) disable iff (!resetn)
    s_r.ovf && !clr |=> s_r.ovf)
    else $error("overflow flag dropped early");

  a_unf_sticky: assert property ( // RULE6
    @(posedge clk) disable iff (!resetn)
    s_r.unf && !clr |=> s_r.unf)
    else $error("underflow flag dropped early");

  a_empty_read: assert property ( // RULE7
    @(posedge clk) disable iff (!resetn)
    pop_empty && !clr |=> rdata == sample_fifo_pkg::EMPTY_READ && s_r.unf)
    else $error("empty read wrong");

  // ----------------------------------------
  // Data port checks
  // ----------------------------------------
  a_pop_count: assert property ( // RULE8
    @(posedge clk) disable iff (!resetn)
    pop && !pop_empty && !push_valid && !clr
    |=> s_r.level == $past(s_r.level) - 10'h001)
    else $error("pop did not decrement");

  a_pop_data: assert property ( // RULE8
    @(posedge clk) disable iff (!resetn)
    pop && !pop_empty |=> rdata == $past(mem_r[s_r.rptr]))
    else $error("popped byte wrong");

  a_rptr_step: assert property ( // RULE9
    @(posedge clk) disable iff (!resetn)
    pop && !pop_empty && !clr
    |=> s_r.rptr == $past(s_r.rptr) + 9'h001)
    else $error("read pointer did not advance");

  // ----------------------------------------
  // Status register and threshold checks
  // ----------------------------------------
  a_high_read: assert property ( // RULE2
    @(posedge clk) disable iff (!resetn)
    req.rd && req.addr == sample_fifo_pkg::ADDR_HIGH
    |=> rdata == $past(s_r.level[9:2]))
    else $error("high count wrong");

  a_low_reserved: assert property ( // RULE2
    @(posedge clk) disable iff (!resetn)
    req.rd && req.addr == sample_fifo_pkg::ADDR_LOW
    |=> rdata[5:2] == 4'h0)
    else $error("reserved status bits set");

  a_snap_keep: assert property ( // RULE4
    @(posedge clk) disable iff (!resetn)
    req.rd && req.addr == sample_fifo_pkg::ADDR_HIGH && !clr
    ##1 req.rd && req.addr == sample_fifo_pkg::ADDR_LOW && !clr
    |=> rdata[1:0] == $past(s_r.level[1:0], 2)
    && rdata[7:6] == $past({s_r.ovf, s_r.unf}, 2))
    else $error("snapshot lost");

  a_irq_thresh: assert property ( // RULE11
    @(posedge clk) disable iff (!resetn)
    buffer_irq == (s_r.level > {1'b0, s_r.thresh, 1'b0}))
    else $error("irq mismatch");

  a_thresh_reset: assert property ( // RULE11
    @(posedge clk) disable iff (!resetn)
    $rose(resetn) |-> s_r.thresh == sample_fifo_pkg::THRESH_RST)
    else $error("threshold reset value wrong");

  a_thresh_write: assert property ( // RULE11
    @(posedge clk) disable iff (!resetn)
    req.wr && req.addr == sample_fifo_pkg::ADDR_THRESH
    |=> s_r.thresh == $past(req.wdata))
    else $error("threshold write lost");

  // ----------------------------------------
  // Cover points
  // ----------------------------------------
  c_fill_full: cover property (
    @(posedge clk) s_r.level == 10'(sample_fifo_pkg::DEPTH));
  c_overflow: cover property (
    @(posedge clk) push_valid && !push_ok && !clr);
  c_underflow: cover property (@(posedge clk) pop_empty);
  c_block_read: cover property (
    @(posedge clk) pop && !pop_empty ##1 pop);
  c_status_pair: cover property (
    @(posedge clk) req.rd && req.addr == sample_fifo_pkg::ADDR_HIGH
    ##1 req.rd && req.addr == sample_fifo_pkg::ADDR_LOW);
endmodule
`default_nettype wire

//--- verification/host_model.sv
// Host side bus controller model issuing register reads
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic                     clk,
  output var sample_fifo_pkg::reg_req_t req
);
  initial req = '{1'b0, 1'b0, 8'h00, 8'h00};
  // Left high so that calls in a row form a block read
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    req <= '{1'b1, 1'b0, a, 8'h00};
  endtask
  // Released address shows the inverse, never a stale value
  task automatic idle();
    @(negedge clk);
    req <= '{1'b0, 1'b0, ~req.addr, 8'h00};
  endtask
  // One-cycle write strobe; follow with idle or a read
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req <= '{1'b0, 1'b1, a, d};
  endtask
endmodule
`default_nettype wire

//--- verification/tb_sample_fifo_readout.sv
// Testbench of the sample buffer read side
`timescale 1ns/1ps
`default_nettype none
module tb_sample_fifo_readout;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       power_on_enable = 1'b0;
  logic       buffer_flush_cmd = 1'b0;
  logic       push_valid = 1'b0;
  logic [7:0] push_data = 8'h00;
  logic [7:0] rdata;
  logic       buffer_irq;
  logic       pend = 1'b0;
  logic [7:0] mq[$];
  logic [7:0] eq[$];
  logic [3:0] snap = 4'h0;
  logic       ovf = 1'b0;
  logic       unf = 1'b0;
  logic [7:0] thr = sample_fifo_pkg::THRESH_RST;
  logic [31:0] seed = 32'hF63E;
  int         bad_count = 0;
  int         checked = 0;
  sample_fifo_pkg::reg_req_t req;
  initial forever #10 clk = ~clk;
  host_model u_host_model (.clk(clk), .req(req));
  sample_fifo_readout u_sample_fifo_readout (.clk(clk), .resetn(resetn),
    .req(req), .power_on_enable(power_on_enable),
    .buffer_flush_cmd(buffer_flush_cmd), .push_valid(push_valid),
    .push_data(push_data), .rdata(rdata), .buffer_irq(buffer_irq));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic cmp(input string n, input logic [7:0] e, g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic r(input logic [7:0] a);
    logic [9:0] c;
    c = 10'(mq.size());
    if (a == sample_fifo_pkg::ADDR_HIGH) begin
      eq.push_back(c[9:2]);
      snap = {ovf, unf, c[1:0]};
    end else if (a == sample_fifo_pkg::ADDR_LOW)
      eq.push_back({snap[3:2], 4'h0, snap[1:0]});
    else if (a == sample_fifo_pkg::ADDR_THRESH) eq.push_back(thr);
    else if (a != sample_fifo_pkg::ADDR_DATA) eq.push_back(8'h00);
    else if (c == 10'h000) begin
      eq.push_back(8'h00);
      unf = 1'b1;
    end else eq.push_back(mq.pop_front());
    u_host_model.rd(a);
  endtask
  task automatic push(input int n);
    repeat (n) begin
      seed = xs(seed);
      @(negedge clk);
      push_valid <= 1'b1;
      push_data <= seed[7:0];
      if (mq.size() == sample_fifo_pkg::DEPTH) ovf = 1'b1;
      else mq.push_back(seed[7:0]);
      @(negedge clk);
      push_valid <= 1'b0;
    end
  endtask
  task automatic clr(input logic p);
    @(negedge clk);
    power_on_enable <= p;
    buffer_flush_cmd <= ~p;
    @(negedge clk);
    power_on_enable <= 1'b0;
    buffer_flush_cmd <= 1'b0;
    mq.delete();
    {ovf, unf, snap} = 6'h00;
  endtask
  task automatic stat();
    r(sample_fifo_pkg::ADDR_HIGH);
    r(sample_fifo_pkg::ADDR_LOW);
    u_host_model.idle();
  endtask
  task automatic wthr(input logic [7:0] d);
    thr = d;
    u_host_model.wr(sample_fifo_pkg::ADDR_THRESH, d);
    u_host_model.idle();
  endtask
  task automatic irq_chk();
    @(negedge clk);
    cmp("irq", {7'h00, mq.size() > 2 * thr}, {7'h00, buffer_irq});
  endtask
  // One cycle read latency; look half a cycle on, once rdata has settled
  always @(posedge clk) pend <= req.rd;
  always @(negedge clk) begin
    if (pend) cmp("rdata", eq.pop_front(), rdata);
  end
  task automatic print_verdict();
    if (eq.size() != 0) bad_count++;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    // Roughly ten times the expected run length
    #200000;
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (10) @(negedge clk);
    resetn <= 1'b1;
    r(sample_fifo_pkg::ADDR_DATA);
    r(8'h10);
    stat();
    clr(1'b1);
    stat();
    $display("test empty and power on done");
    push(5);
    stat();
    irq_chk();
    r(sample_fifo_pkg::ADDR_THRESH);
    wthr(8'h02);
    irq_chk();
    push(3);
    stat();
    repeat (8) r(sample_fifo_pkg::ADDR_DATA);
    stat();
    $display("test snapshot and block read done");
    push(513);
    irq_chk();
    stat();
    clr(1'b0);
    stat();
    irq_chk();
    @(negedge clk);
    $display("test full and flush done");
    print_verdict();
  end
endmodule
`default_nettype wire
